// File: rtl/rbe_defines.svh
`ifndef RBE_DEFINES_SVH
`define RBE_DEFINES_SVH
// register byte offsets and reset value
`define RBE_CTRL_OFS   8'h00
`define RBE_STAT_OFS   8'h04
`define RBE_CTRL_RST   32'h0000_15f0
// three-level pin codes
`define RBE_LVL_LO     2'h0
`define RBE_LVL_MID    2'h1
`define RBE_LVL_HI     2'h2
// elasticity buffer geometry and marks
`define RBE_EB_DEPTH   4'ha
`define RBE_EB_HALF    4'h5
`define RBE_EB_LOW     4'h2
`define RBE_EB_HIGH    4'h8
`define RBE_FRM_CENTER 3'h4
// checker constants
`define RBE_ABORT_DIFF 5'h10
`define RBE_LFSR_START 9'h0ff
`define RBE_LFSR_VIOL  9'h1ff
`define RBE_K28_5      8'hbc
// status field codes
`define RBE_ST_DAT     3'h0
`define RBE_ST_SPC     3'h1
`define RBE_ST_FRM     3'h3
`define RBE_ST_INV     3'h7
`define RBE_BS_OK      3'h1
`define RBE_BS_LOOP_A  3'h2
`define RBE_BS_LOOP_B  3'h4
`define RBE_BS_MISS    3'h5
`define RBE_BS_WAIT    3'h6
`endif

// File: rtl/rbe_pkg.sv
`include "rbe_defines.svh"
package rbe_pkg;
  // character from framer/decoder
  typedef struct packed {
    logic [7:0] data;
    logic       kchar;
    logic       frm;
    logic       viol;
  } rbe_rxch_t;
  // one buffer entry, twelve bits
  typedef struct packed {
    logic       par;
    logic [2:0] rx_status_field;
    logic [7:0] data;
  } rbe_ent_t;
  typedef enum logic [2:0] {
    BS_IDLE = 3'b001,
    BS_SRCH = 3'b010,
    BS_RUN  = 3'b100
  } rbe_bst_t;
  typedef struct packed {
    rbe_bst_t   st;
    logic [8:0] lfsr;
    logic [4:0] diff;
  } rbe_chk_t;
  typedef struct packed {
    rbe_ent_t [`RBE_EB_DEPTH-1:0] mem;
    logic [3:0] rp;
    logic [3:0] wp;
    logic [3:0] cnt;
    logic [2:0] fr_run;
    logic       algn;
  } rbe_buf_t;
  typedef struct packed {
    logic [11:0] rsvd_hi;
    logic        clock_select_in_lo;
    logic        clock_select_in_hi;
    logic [1:0]  mode_hi;
    logic [1:0]  mode_lo;
    logic [1:0]  framer_mode_select;
    logic [1:0]  decoder_mode_select;
    logic [1:0]  rx_clock_select;
    logic [3:0]  per_channel_select_in;
    logic [2:0]  rsvd_lo;
    logic        selftest_latch_enable;
  } rbe_ctrl_t;
  typedef struct packed {
    logic [17:0] rsvd;
    logic        cfg_err;
    logic        mode_err;
    logic [3:0]  aligned;
    logic [3:0]  running;
    logic [3:0]  latch;
  } rbe_stat_t;
  typedef struct packed {
    rbe_ctrl_t       ctrl;
    logic [3:0]      latch;
    rbe_chk_t [3:0]  chk;
    rbe_buf_t [3:0]  eb;
    rbe_ent_t [3:0]  out;
    logic [3:0]      ostb;
    logic            wr_ph;
    logic [7:0]      wad;
    logic [31:0]     rdata;
  } rbe_state_t;
endpackage

// File: rtl/rbe_rx_backend.sv
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "rbe_defines.svh"
// Overview of operation
// - latch-enable high: low select enables channel BIST
// - latch-enable fall captures selects into latch
// - reset sets every latch bit, BIST off
// - enabled checker runs 511-character LFSR sequence
// - common clock: pass preceded by word sync
// - synchronized checker compares, reports on status field
// - first enable presets LFSR to D0.0 start
// - expected violations in loop raise no error
// - loop completion shows 010b/100b one character
// - invalid exceeding valid by sixteen aborts, resynchronizes
// - transmitter inserts word sync before each pass
// - buffer holds ten twelve-bit entries
// - buffer written by own channel's recovered clock
// - read clock: reference low, selected recovered high
// - decoder bypass also bypasses buffer, needs middle select
// - two-bit mode: bonding, status variant, middle forbidden
// - select low: reference clock, B/D off, insert/delete
// - insert/delete only with framing character buffered
// - middle select: own recovered clock, buffer bypassed
// - select high: one chosen recovered clock, no insert/delete
// - buffer centered by sync, framing run or reset; a framing run only trims a buffer holding more than half
// - decoded status: 000b data, 001b special, others
module rbe_rx_backend
  import rbe_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic      [31:0]     hrdata,
  output logic                 hreadyout,
  output logic                 hresp,
  input  wire rbe_rxch_t [3:0] rx_char,
  input  wire logic [3:0]      rx_char_stb,
  input  wire logic            ref_char_en,
  output rbe_ent_t  [3:0]      rx_out,
  output logic      [3:0]      rx_out_stb,
  output logic                 rx_clock_out_a,
  output logic                 rx_clock_out_b,
  output logic                 rx_clock_out_c,
  output logic                 rx_clock_out_d,
  output logic                 rx_clock_bd_oe
);

  rbe_state_t s_q;
  rbe_state_t s_d;
  logic [3:0] byp_w;
  logic [3:0] ins_w;
  logic [3:0] del_w;
  logic [3:0] hf_w;
  logic [3:0] ok_w;

  // maximal 9-bit sequence, period 511
  function automatic logic [8:0] lfsr_next(input logic [8:0] l);
    return {l[7:0], l[8] ^ l[4]};
  endfunction

  // expected character: start state maps to D0.0
  function automatic logic [8:0] exp_char(input logic [8:0] l);
    return {l[8], ~l[7:0]};
  endfunction

  function automatic logic [3:0] inc10(input logic [3:0] x);
    return (x == `RBE_EB_DEPTH - 4'h1) ? 4'h0 : x + 4'h1;
  endfunction

  function automatic logic is_frm(input rbe_ent_t e);
    // received framing carries the framing code, inserted ones the special code
    return e.data == `RBE_K28_5 &&
           (e.rx_status_field == `RBE_ST_SPC || e.rx_status_field == `RBE_ST_FRM);
  endfunction

  // any framing character among occupied entries
  function automatic logic has_frm(input rbe_buf_t b);
    logic r;
    logic [3:0] off;
    r = 1'b0;
    for (int i = 0; i < 10; i++) begin
      off = 4'(i) + ((4'(i) >= b.rp) ? 4'h0 : `RBE_EB_DEPTH) - b.rp;
      if (off < b.cnt && is_frm(b.mem[i])) r = 1'b1;
    end
    return r;
  endfunction

  logic       ck_lo;
  logic       ck_mid;
  logic [1:0] ck_idx;
  logic [3:0] eff_sel;
  assign ck_lo   = s_q.ctrl.rx_clock_select == `RBE_LVL_LO;
  assign ck_mid  = s_q.ctrl.rx_clock_select == `RBE_LVL_MID;
  assign ck_idx  = {s_q.ctrl.clock_select_in_hi, s_q.ctrl.clock_select_in_lo};
  // latch is transparent while enable is high
  assign eff_sel = s_q.ctrl.selftest_latch_enable ?
                   s_q.ctrl.per_channel_select_in : s_q.latch;

  // next-state logic for everything
  always_comb begin
    rbe_ent_t   we;
    rbe_ent_t   ins_e;
    rbe_stat_t  st;
    logic [2:0] dst;
    logic [2:0] bst;
    logic [2:0] lcode;
    logic       en;
    logic       push;
    logic       pop;
    logic       rd;
    logic       flex;
    logic       ctr;
    logic       merr;
    we    = '0;
    ins_e = '0;
    st    = '0;
    dst   = `RBE_ST_DAT;
    bst   = `RBE_BS_WAIT;
    en    = 1'b0;
    push  = 1'b0;
    pop   = 1'b0;
    rd    = 1'b0;
    ctr   = 1'b0;
    byp_w = '0;
    ins_w = '0;
    del_w = '0;
    hf_w  = '0;
    ok_w  = '0;
    s_d   = s_q;
    s_d.ostb = '0;
    merr  = s_q.ctrl.mode_lo == `RBE_LVL_MID || s_q.ctrl.mode_lo == 2'h3;
    lcode = (s_q.ctrl.mode_lo == `RBE_LVL_HI) ? `RBE_BS_LOOP_B : `RBE_BS_LOOP_A;
    flex  = ck_lo;
    ins_e = '{par: ~^`RBE_K28_5, rx_status_field: `RBE_ST_SPC, data: `RBE_K28_5};
    // bus write lands in the data phase
    if (s_q.wr_ph && s_q.wad == `RBE_CTRL_OFS) s_d.ctrl = rbe_ctrl_t'(hwdata);
    // capture on falling enable, hold while low
    if (s_q.ctrl.selftest_latch_enable) s_d.latch = s_q.ctrl.per_channel_select_in;
    for (int c = 0; c < 4; c++) begin
      // each channel owns its checker and buffer
      en = !eff_sel[c];
      dst = rx_char[c].viol ? `RBE_ST_INV : rx_char[c].frm ? `RBE_ST_FRM :
            rx_char[c].kchar ? `RBE_ST_SPC : `RBE_ST_DAT;
      ok_w[c] = {rx_char[c].kchar, rx_char[c].data} == exp_char(s_q.chk[c].lfsr) ||
                (s_q.chk[c].lfsr == `RBE_LFSR_VIOL && rx_char[c].viol);
      bst = `RBE_BS_WAIT;
      unique case (s_q.chk[c].st)
        BS_IDLE: begin
          if (en) begin
            s_d.chk[c].st   = BS_SRCH;
            s_d.chk[c].lfsr = `RBE_LFSR_START;
            s_d.chk[c].diff = '0;
          end
        end
        BS_SRCH: begin
          // word sync and other filler skipped until D0.0 arrives
          if (!en) s_d.chk[c].st = BS_IDLE;
          else if (rx_char_stb[c] && ok_w[c]) begin
            s_d.chk[c].st   = BS_RUN;
            s_d.chk[c].lfsr = lfsr_next(s_q.chk[c].lfsr);
            bst = `RBE_BS_OK;
          end
        end
        BS_RUN: begin
          if (!en) s_d.chk[c].st = BS_IDLE;
          else if (rx_char_stb[c] && ok_w[c]) begin
            s_d.chk[c].lfsr = lfsr_next(s_q.chk[c].lfsr);
            if (s_q.chk[c].diff != '0) s_d.chk[c].diff = s_q.chk[c].diff - 5'h1;
            bst = `RBE_BS_OK;
            if (lfsr_next(s_q.chk[c].lfsr) == `RBE_LFSR_START) begin
              bst = lcode;
              // common clock: next pass opens with word sync
              if (!ck_mid) s_d.chk[c].st = BS_SRCH;
            end
          end else if (rx_char_stb[c]) begin
            bst = `RBE_BS_MISS;
            s_d.chk[c].lfsr = lfsr_next(s_q.chk[c].lfsr);
            s_d.chk[c].diff = s_q.chk[c].diff + 5'h1;
            if (s_q.chk[c].diff + 5'h1 == `RBE_ABORT_DIFF) begin
              s_d.chk[c].st   = BS_SRCH;
              s_d.chk[c].lfsr = `RBE_LFSR_START;
              s_d.chk[c].diff = '0;
            end
          end
        end
        default: s_d.chk[c].st = BS_IDLE;
      endcase
      // checker status wins regardless of decoder mode
      we.data = rx_char[c].data;
      we.rx_status_field = en ? bst : dst;
      we.par = ~^rx_char[c].data;
      byp_w[c] = s_q.ctrl.decoder_mode_select == `RBE_LVL_LO || ck_mid;
      if (byp_w[c]) begin
        // straight to the output register on own recovered clock
        if (rx_char_stb[c]) begin
          s_d.out[c]  = we;
          s_d.ostb[c] = 1'b1;
        end
      end else begin
        hf_w[c] = has_frm(s_q.eb[c]);
        rd = ck_lo ? ref_char_en : rx_char_stb[ck_idx];
        // a run of framing characters re-centers an overfull buffer
        ctr = rx_char_stb[c] && rx_char[c].frm &&
              s_q.eb[c].fr_run == `RBE_FRM_CENTER - 3'h1;
        if (rx_char_stb[c])
          s_d.eb[c].fr_run = !rx_char[c].frm ? 3'h0 :
            (s_q.eb[c].fr_run == `RBE_FRM_CENTER) ? s_q.eb[c].fr_run :
            s_q.eb[c].fr_run + 3'h1;
        del_w[c] = flex && rx_char_stb[c] && rx_char[c].frm &&
                   s_q.eb[c].cnt >= `RBE_EB_HIGH && hf_w[c];
        push = rx_char_stb[c] && !del_w[c] && s_q.eb[c].cnt != `RBE_EB_DEPTH;
        // strict mark: a framing char with data behind it is still drained
        ins_w[c] = flex && rd && s_q.eb[c].cnt < `RBE_EB_LOW && hf_w[c];
        pop = rd && !ins_w[c] && s_q.eb[c].cnt != 4'h0;
        if (push) begin
          s_d.eb[c].mem[s_q.eb[c].wp] = we;
          s_d.eb[c].wp = inc10(s_q.eb[c].wp);
        end
        if (pop) begin
          s_d.out[c] = s_q.eb[c].mem[s_q.eb[c].rp];
          s_d.eb[c].rp = inc10(s_q.eb[c].rp);
        end else if (ins_w[c]) begin
          s_d.out[c] = ins_e;
        end
        s_d.ostb[c] = pop || ins_w[c];
        s_d.eb[c].cnt = s_q.eb[c].cnt + {3'h0, push} - {3'h0, pop};
        if (ctr) begin
          // trim an overfull buffer to the newest half; never replay stale slots
          if (s_d.eb[c].cnt > `RBE_EB_HALF) begin
            s_d.eb[c].rp  = (s_d.eb[c].wp >= `RBE_EB_HALF) ?
                            s_d.eb[c].wp - `RBE_EB_HALF :
                            s_d.eb[c].wp + `RBE_EB_DEPTH - `RBE_EB_HALF;
            s_d.eb[c].cnt = `RBE_EB_HALF;
          end
          s_d.eb[c].algn = 1'b1;
        end
      end
      st.running[c] = s_q.chk[c].st == BS_RUN;
      st.aligned[c] = s_q.eb[c].algn;
    end
    // report the value the latch takes at this edge, so a read sees the write
    st.latch    = s_d.latch;
    st.mode_err = merr;
    // far-side misconfigurations are flagged, not prevented
    st.cfg_err  = (s_q.ctrl.decoder_mode_select == `RBE_LVL_LO && !ck_mid) ||
                  (s_q.ctrl.framer_mode_select == `RBE_LVL_LO && eff_sel != 4'hf);
    // address phase, zero wait states
    s_d.wr_ph = hsel && htrans[1] && hready && hwrite;
    s_d.wad   = haddr[7:0];
    if (hsel && htrans[1] && hready && !hwrite)
      s_d.rdata = (haddr[7:0] == `RBE_CTRL_OFS) ? 32'(s_d.ctrl) :
                  (haddr[7:0] == `RBE_STAT_OFS) ? 32'(st) : 32'h0;
  end

  // one register for all state; reset centers buffers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q       <= '0;
      s_q.ctrl  <= rbe_ctrl_t'(`RBE_CTRL_RST);
      s_q.latch <= 4'hf;
      for (int c = 0; c < 4; c++) begin
        s_q.chk[c].st  <= BS_IDLE;
        s_q.eb[c].wp   <= `RBE_EB_HALF;
        s_q.eb[c].cnt  <= `RBE_EB_HALF;
      end
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata     = s_q.rdata;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign rx_out     = s_q.out;
  assign rx_out_stb = s_q.ostb;

  // output clocks as character enables; B/D float in reference mode
  always_comb begin
    rx_clock_bd_oe = !ck_lo;
    rx_clock_out_b = ck_mid && rx_char_stb[1];
    rx_clock_out_d = ck_mid && rx_char_stb[3];
    if (ck_lo) begin
      rx_clock_out_a = ref_char_en;
      rx_clock_out_c = ref_char_en;
    end else if (ck_mid) begin
      rx_clock_out_a = rx_char_stb[0];
      rx_clock_out_c = rx_char_stb[2];
    end else begin
      rx_clock_out_a = rx_char_stb[ck_idx];
      rx_clock_out_c = rx_char_stb[ck_idx];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_enable_starts: assert property (s_q.chk[0].st == BS_IDLE && !eff_sel[0]
    |=> s_q.chk[0].st == BS_SRCH && s_q.chk[0].lfsr == `RBE_LFSR_START)
    else $error("enabled checker did not preset");
  a_latch_hold: assert property (!s_q.ctrl.selftest_latch_enable &&
    $past(!s_q.ctrl.selftest_latch_enable) |-> $stable(s_q.latch))
    else $error("latch changed while closed");
  a_reset_latch: assert property ($past(!hresetn) |-> s_q.latch == 4'hf)
    else $error("latch not set after reset");
  a_abort_bound: assert property (s_q.chk[0].diff < `RBE_ABORT_DIFF)
    else $error("abort threshold passed");
  a_loop_single: assert property (s_q.ostb[0] && $past(byp_w[0]) && $past(!eff_sel[0]) &&
    (s_q.out[0].rx_status_field == `RBE_BS_LOOP_A ||
     s_q.out[0].rx_status_field == `RBE_BS_LOOP_B)
    |-> s_q.chk[0].lfsr == `RBE_LFSR_START)
    else $error("loop status away from loop end");
  a_buf_bound: assert property (s_q.eb[0].cnt <= `RBE_EB_DEPTH)
    else $error("buffer over depth");
  a_bypass_still: assert property (byp_w[0] |=> $stable(s_q.eb[0].cnt))
    else $error("buffer moved while bypassed");
  a_insert_frm: assert property (ins_w[0] |-> hf_w[0] && ck_lo
    ##1 s_q.ostb[0] && s_q.out[0].data == `RBE_K28_5)
    else $error("bad insertion");
  a_delete_frm: assert property (del_w[0] |-> hf_w[0] && ck_lo)
    else $error("bad deletion");
  a_bd_hiz: assert property (ck_lo |-> !rx_clock_bd_oe && rx_clock_out_a == ref_char_en)
    else $error("reference clock mode outputs wrong");

  c_bist_run: cover property (s_q.chk[0].st == BS_SRCH ##1 s_q.chk[0].st == BS_RUN);
  c_abort: cover property (s_q.chk[0].st == BS_RUN ##1 s_q.chk[0].st == BS_SRCH);
  c_insert: cover property (ins_w[0]);
  c_delete: cover property (del_w[0]);

endmodule // rbe_rx_backend

// File: verif/rbe_far_tx.sv
`timescale 1ns/1ps
`include "rbe_defines.svh"
// far end: remote transmitter feeding decoded characters per channel
module rbe_far_tx
  import rbe_pkg::*;
(
  input  wire logic            hclk,
  output rbe_rxch_t [3:0]      rx_char,
  output logic      [3:0]      rx_char_stb
);
  localparam rbe_rxch_t sync_ch = '{data: `RBE_K28_5, kchar: 1'b1, frm: 1'b1, viol: 1'b0};

  // idle at time zero, lines never left holding a stale value
  initial begin
    rx_char     = '0;
    rx_char_stb = '0;
  end

  // optional 16-character word sync, then one character; gap sets pace
  task automatic send(input logic [1:0] c, input rbe_rxch_t x, input bit ws, input int gap);
    for (int i = ws ? 0 : 16; i <= 16; i++) begin
      @(posedge hclk);
      rx_char[c]     <= (i < 16) ? sync_ch : x;
      rx_char_stb[c] <= 1'b1;
      @(posedge hclk);
      rx_char_stb[c] <= 1'b0;
      rx_char[c]     <= ~((i < 16) ? sync_ch : x); // inverted so stale data cannot match
      repeat (gap) @(posedge hclk);
    end
  endtask
endmodule // rbe_far_tx

// File: verif/tb.sv
`timescale 1ns/1ps
`include "rbe_defines.svh"
module tb
  import rbe_pkg::*;
;
  localparam logic [31:0] ctrl_adr = {24'h0, `RBE_CTRL_OFS};
  localparam logic [31:0] stat_adr = {24'h0, `RBE_STAT_OFS};
  logic            hclk;
  logic            hresetn;
  logic            hsel;
  logic [31:0]     haddr;
  logic [1:0]      htrans;
  logic            hwrite;
  logic [2:0]      hsize;
  logic [31:0]     hwdata;
  logic [31:0]     hrdata;
  logic            hreadyout;
  logic            hresp;
  logic            ref_char_en;
  rbe_rxch_t [3:0] rx_char;
  logic [3:0]      rx_char_stb;
  rbe_ent_t  [3:0] rx_out;
  logic [3:0]      rx_out_stb;
  logic            ck_a;
  logic            ck_b;
  logic            ck_c;
  logic            ck_d;
  logic            bd_oe;
  rbe_ctrl_t       ctrl;
  logic [31:0]     rd;
  rbe_ent_t        got[4][$];
  int              bad_count;
  int              n_compared;

  rbe_rx_backend dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_char(rx_char),
    .rx_char_stb(rx_char_stb), .ref_char_en(ref_char_en), .rx_out(rx_out),
    .rx_out_stb(rx_out_stb), .rx_clock_out_a(ck_a), .rx_clock_out_b(ck_b),
    .rx_clock_out_c(ck_c), .rx_clock_out_d(ck_d), .rx_clock_bd_oe(bd_oe));
  rbe_far_tx far_u (.hclk(hclk), .rx_char(rx_char), .rx_char_stb(rx_char_stb));

  // 20 mhz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  // log every character leaving the block, mid-cycle where it is settled
  always @(negedge hclk)
    for (int c = 0; c < 4; c++)
      if (rx_out_stb[c] === 1'b1)
        got[c].push_back(rx_out[c]);

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    for (int k = 0; k < 50; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        return;
    end
    bad_count++;
    $display("BAD hready expected 1 seen timeout");
    wrap_up();
  endtask

  // one single ahb-lite word transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic setc();
    bus(1'b1, ctrl_adr, ctrl);
  endtask

  task automatic rstat();
    bus(1'b0, stat_adr, 32'h0);
  endtask

  function automatic rbe_rxch_t dch(input logic [7:0] d, input logic k = 1'b0);
    return '{data: d, kchar: k, frm: 1'b0, viol: 1'b0};
  endfunction

  task automatic ref_pulses(input int n, input int gap);
    repeat (n) begin
      @(posedge hclk);
      ref_char_en <= 1'b1;
      @(posedge hclk);
      ref_char_en <= 1'b0;
      repeat (gap) @(posedge hclk);
    end
  endtask

  // output clocks a and c must track the expected strobes each cycle
  task automatic watch(input int ka, input int kc);
    repeat (8) begin
      @(posedge hclk);
      #1;
      check("clock a", ck_a, rx_char_stb[ka]);
      check("clock c", ck_c, rx_char_stb[kc]);
    end
  endtask

  task automatic clear();
    foreach (got[c])
      got[c].delete();
  endtask

  task automatic t_regs();
    bus(1'b0, ctrl_adr, 32'h0);
    check("ctrl reset", rd, `RBE_CTRL_RST);
    rstat();
    check("latch reset", rd[3:0], 4'hf);
    bus(1'b0, 32'h0000_0040, 32'h0);
    check("unmapped", rd, 32'h0);
    bus(1'b1, stat_adr, 32'hffff_ffff);
    rstat();
    check("stat read only", rd[13:0], 14'h000f);
    check("hresp", hresp, 1'b0);
    $display("test regs done");
  endtask

  // reset leaves five centred entries; no framing held, so no insertion
  task automatic t_drain();
    ctrl.rx_clock_select = `RBE_LVL_LO;
    setc();
    ref_pulses(12, 0);
    @(posedge hclk);
    ref_char_en <= 1'b1;
    #1;
    check("ref clock a", ck_a, 1'b1);
    check("ref clock c", ck_c, 1'b1);
    check("bd enable", bd_oe, 1'b0);
    @(posedge hclk);
    ref_char_en <= 1'b0;
    repeat (3) @(posedge hclk);
    for (int c = 0; c < 4; c++)
      check("reset fill", got[c].size(), 5);
    clear();
    $display("test drain done");
  endtask

  // matched rates through the buffer; only k28.5 may be added
  task automatic t_stream();
    int k;
    k = 0;
    fork
      for (int i = 0; i < 4; i++)
        far_u.send(2'd0, dch(8'h11 + 8'(i)), i == 0, 2);
      ref_pulses(40, 2);
    join
    repeat (3) @(posedge hclk);
    foreach (got[0][i])
      if (got[0][i].rx_status_field === `RBE_ST_DAT) begin
        check("stream data", got[0][i].data, 8'h11 + 8'(k));
        k++;
      end else if (got[0][i].rx_status_field === `RBE_ST_FRM)
        check("sync", got[0][i].data, `RBE_K28_5);
      else
        check("filler", got[0][i][10:0], {`RBE_ST_SPC, `RBE_K28_5});
    check("stream count", k, 4);
    clear();
    $display("test stream done");
  endtask

  // writer without reader: surplus framing must be deleted, data kept
  task automatic t_delete();
    int nf;
    int nd;
    nf = 0;
    nd = 0;
    far_u.send(2'd0, dch(8'h21), 1'b1, 0);
    ref_pulses(14, 0);
    repeat (3) @(posedge hclk);
    foreach (got[0][i])
      if (got[0][i].rx_status_field === `RBE_ST_DAT) begin
        check("kept data", got[0][i].data, 8'h21);
        nd++;
      end else
        nf++;
    check("depth bound", nf <= 9, 1'b1);
    check("data kept", nd, 1);
    clear();
    $display("test delete done");
  endtask

  task automatic t_clksel();
    for (int k = 0; k < 4; k++) begin
      ctrl.rx_clock_select    = `RBE_LVL_HI;
      ctrl.clock_select_in_hi = k[1];
      ctrl.clock_select_in_lo = k[0];
      setc();
      fork
        far_u.send(2'(k), dch(8'h30), 1'b0, 1);
        watch(k, k);
      join
    end
    clear();
    $display("test clock select done");
  endtask

  // decoder bypass needs the middle select; own clocks drive c
  task automatic t_bypass();
    ctrl.rx_clock_select     = `RBE_LVL_MID;
    ctrl.decoder_mode_select = `RBE_LVL_LO;
    setc();
    rstat();
    check("cfg fine", rd[13], 1'b0);
    fork
      far_u.send(2'd2, dch(8'h5a), 1'b0, 0);
      watch(0, 2);
    join
    @(posedge hclk);
    check("bypass count", got[2].size(), 1);
    check("bypass data", got[2][0].data, 8'h5a);
    ctrl.rx_clock_select = `RBE_LVL_LO;
    setc();
    rstat();
    check("cfg fault", rd[13], 1'b1);
    ctrl.rx_clock_select     = `RBE_LVL_MID;
    ctrl.decoder_mode_select = `RBE_LVL_MID;
    setc();
    far_u.send(2'd2, dch(8'h3c, 1'b1), 1'b0, 0);
    repeat (2) @(posedge hclk);
    check("special", got[2][1].rx_status_field, `RBE_ST_SPC);
    clear();
    $display("test bypass done");
  endtask

  task automatic t_mode();
    for (int m = 0; m < 4; m++) begin
      ctrl.mode_lo = 2'(m);
      setc();
      rstat();
      check("mode fault", rd[12], m == 1 || m == 3);
    end
    ctrl.mode_lo = `RBE_LVL_LO;
    setc();
    $display("test mode done");
  endtask

  // framer stays multi-byte during self test
  task automatic t_bist();
    ctrl.selftest_latch_enable = 1'b1;
    ctrl.per_channel_select_in = 4'he;
    setc();
    rstat();
    check("latch open", rd[3:0], 4'he);
    ctrl.selftest_latch_enable = 1'b0;
    setc();
    ctrl.per_channel_select_in = 4'hf;
    setc();
    rstat();
    check("latch held", rd[3:0], 4'he);
    // junk, start code, repeated start code, then a long run of junk
    for (int i = 0; i < 27; i++)
      far_u.send(2'd0, dch((i == 1 || i == 2) ? 8'h00 : 8'h55), 1'b0, 0);
    far_u.send(2'd1, dch(8'h55), 1'b0, 0);
    repeat (2) @(posedge hclk);
    check("bist count", got[0].size(), 27);
    check("bist wait", got[0][0].rx_status_field, `RBE_BS_WAIT);
    check("bist miss", got[0][2].rx_status_field, `RBE_BS_MISS);
    check("bist abort", got[0][26].rx_status_field, `RBE_BS_WAIT);
    check("other chan", got[1][0].rx_status_field, `RBE_ST_DAT);
    clear();
    $display("test bist done");
  endtask

  // overall time limit
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    $display("BAD run time expected end seen timeout");
    wrap_up();
  end

  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = 3'b010;
    hwdata      = 32'h0;
    ref_char_en = 1'b0;
    bad_count   = 0;
    n_compared  = 0;
    ctrl        = `RBE_CTRL_RST;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_drain();
    t_stream();
    t_delete();
    t_clksel();
    t_bypass();
    t_mode();
    t_bist();
    wrap_up();
  end
endmodule // tb
